// [hw/aam_monitor.sv]
`timescale 1ns/10ps

// Behaviour
// - the high-speed controller code is never acknowledged
// - repeated start in high-speed mode keeps high-speed mode
// - stop ends high-speed mode; entry must be repeated afterwards
// - select input picks 1010000 float, 1010001 ground, 1010010 supply
// - fixed variant answers only address 1010100
// - each finished conversion is compared to upper and lower limits
// - above upper sets over-range, below lower sets under-range
// - flag-enable makes an alert set the result msb
// - pin-enable makes an alert drive the alert output active
// - polarity bit: clear means active low, set means active high
// - writing one to a flag clears it whatever the hold bit
// - hold clear: over clears below upper minus hysteresis
// - hold clear: under clears above lower plus hysteresis
// - hold set: alerts persist until software writes one
// - a cleared flag sets again if the next result still violates
// - only sampled conversion results are judged
// - nonzero cycle field runs automatic conversions at that rate
// - automatic mode keeps the oscillator on and updates state
// - automatic results update lowest and highest trackers
// - trackers hold until software writes them
// - write carries pointer first; read uses current pointer
// - writing zero to highest tracker clears it
module aam_monitor
#(
  parameter bit HAS_ADDR_PIN = 1'b1,
  parameter int AUTO_BASE = aam_pkg::AUTO_BASE_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [aam_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic osc_enable,
  output logic alert_out,
  output logic hs_active
);
  import aam_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] config_q;
  logic [11:0] low_lim, high_lim, hyst, lowest, highest, result;
  logic over_q, under_q, hs_mode;
  logic [2:0] pointer;

  function automatic logic [6:0] addr_of(input logic [1:0] code);
    case (code)
      SEL_GND: addr_of = ADDR_GND;
      SEL_SUPPLY: addr_of = ADDR_SUPPLY;
      default: addr_of = ADDR_FLOAT;
    endcase
  endfunction

  function automatic logic one_byte(input logic [2:0] idx);
    one_byte = (idx == REG_STATUS) || (idx == REG_CONFIG);
  endfunction

  wire logic alert_any = over_q | under_q;
  wire logic flag_en = config_q[CFG_FLAG_EN];
  wire logic [2:0] cyc = config_q[CFG_CYC_MSB:CFG_CYC_LSB];
  wire logic auto_mode = (cyc != 3'h0);

  function automatic logic [15:0] reg_value(input logic [2:0] idx);
    case (idx)
      REG_RESULT: reg_value = {flag_en & alert_any, 3'h0, result};
      REG_STATUS: reg_value = {8'h00, 3'h0, hs_mode, 2'h0, over_q, under_q};
      REG_CONFIG: reg_value = {8'h00, config_q};
      REG_LOW_LIM: reg_value = {4'h0, low_lim};
      REG_HIGH_LIM: reg_value = {4'h0, high_lim};
      REG_HYST: reg_value = {4'h0, hyst};
      REG_LOWEST: reg_value = {4'h0, lowest};
      default: reg_value = {4'h0, highest};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic [1:0] sel_m, sel_s;
  logic strap_done;
  logic [6:0] my_addr;

  always_ff @(posedge clock)
  begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    scl_q <= scl_s;
    sda_m <= sda_in;
    sda_s <= sda_m;
    sda_q <= sda_s;
    sel_m <= addr_sel;
    sel_s <= sel_m;
  end

  // strap is caught once after release, not by the reset itself
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strap_done <= 1'b0;
      my_addr <= ADDR_FIXED;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      my_addr <= HAS_ADDR_PIN ? addr_of(sel_s) : ADDR_FIXED;
    end
  end

  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire logic stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // i2c target
  // ----------------------------------------------------------------
  aam_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx_sh, hi_byte;
  logic [1:0] byte_cnt;
  logic rw, tx_upper, mack, drv_low;
  logic [15:0] rd_word;
  logic i2c_wr_stb, rd_trig;
  logic [2:0] i2c_wr_idx;
  logic [15:0] i2c_wr_data;

  wire logic byte_end = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8);
  wire logic is_hs_code = (shreg[7:3] == HS_CODE_TOP);
  wire logic addr_hit = (shreg[7:1] == my_addr);
  logic [15:0] ptr_value;

  // procedural call: follows every register the function reads, not only its argument
  always_comb
  begin
    ptr_value = reg_value(pointer);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx_sh <= 8'h00;
      hi_byte <= 8'h00;
      byte_cnt <= 2'h0;
      rw <= 1'b0;
      tx_upper <= 1'b1;
      mack <= 1'b0;
      drv_low <= 1'b0;
      rd_word <= 16'h0000;
      hs_mode <= 1'b0;
      pointer <= REG_RESULT;
      i2c_wr_stb <= 1'b0;
      i2c_wr_idx <= REG_RESULT;
      i2c_wr_data <= 16'h0000;
      rd_trig <= 1'b0;
    end
    else
    begin
      i2c_wr_stb <= 1'b0;
      rd_trig <= 1'b0;
      if (stop_det)
      begin
        state <= ST_IDLE;
        hs_mode <= 1'b0;
        drv_low <= 1'b0;
      end
      else if (start_det)
      begin
        // repeated start leaves hs_mode alone
        state <= ST_RX;
        bit_cnt <= 4'h0;
        byte_cnt <= 2'h0;
        drv_low <= 1'b0;
      end
      else
      begin
        case (state)
          ST_RX:
          begin
            if (scl_rise && bit_cnt != 4'h8)
            begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (byte_end)
            begin
              if (byte_cnt == 2'h0)
              begin
                if (is_hs_code)
                begin
                  hs_mode <= 1'b1;
                  state <= ST_IDLE;
                end
                else if (addr_hit)
                begin
                  rw <= shreg[0];
                  drv_low <= 1'b1;
                  state <= ST_ACK;
                  byte_cnt <= 2'h1;
                  tx_upper <= 1'b1;
                  rd_trig <= shreg[0] && (pointer == REG_RESULT);
                end
                else
                begin
                  state <= ST_IDLE;
                end
              end
              else
              begin
                drv_low <= 1'b1;
                state <= ST_ACK;
                if (byte_cnt == 2'h1)
                begin
                  pointer <= shreg[2:0];
                  byte_cnt <= 2'h2;
                end
                else if (byte_cnt == 2'h2 && one_byte(pointer))
                begin
                  i2c_wr_stb <= 1'b1;
                  i2c_wr_idx <= pointer;
                  i2c_wr_data <= {8'h00, shreg};
                end
                else if (byte_cnt == 2'h2)
                begin
                  hi_byte <= shreg;
                  byte_cnt <= 2'h3;
                end
                else
                begin
                  i2c_wr_stb <= 1'b1;
                  i2c_wr_idx <= pointer;
                  i2c_wr_data <= {hi_byte, shreg};
                  byte_cnt <= 2'h2;
                end
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= rw ? 4'h1 : 4'h0;
              state <= rw ? ST_TX : ST_RX;
              if (rw)
              begin
                // quiet reads only stretch the wait before this byte
                rd_word <= ptr_value;
                tx_sh <= {ptr_value[14:8], 1'b0};
                drv_low <= ~(one_byte(pointer) ? ptr_value[7] : ptr_value[15]);
                if (one_byte(pointer))
                begin
                  tx_sh <= {ptr_value[6:0], 1'b0};
                end
              end
              else
              begin
                drv_low <= 1'b0;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall && bit_cnt == 4'h8)
            begin
              drv_low <= 1'b0;
              state <= ST_RACK;
              tx_upper <= ~tx_upper | one_byte(pointer);
            end
            else if (scl_fall)
            begin
              drv_low <= ~tx_sh[7];
              tx_sh <= {tx_sh[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              mack <= ~sda_s;
            end
            else if (scl_fall && !mack)
            begin
              state <= ST_IDLE;
            end
            else if (scl_fall)
            begin
              state <= ST_TX;
              bit_cnt <= 4'h1;
              if (tx_upper)
              begin
                rd_word <= ptr_value;
                drv_low <= ~(one_byte(pointer) ? ptr_value[7] : ptr_value[15]);
                tx_sh <= one_byte(pointer) ? {ptr_value[6:0], 1'b0}
                                           : {ptr_value[14:8], 1'b0};
              end
              else
              begin
                drv_low <= ~rd_word[7];
                tx_sh <= {rd_word[6:0], 1'b0};
              end
            end
          end
          default:
          begin
            drv_low <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drv_low;
  assign hs_active = hs_mode;

  // ----------------------------------------------------------------
  // avalon slave and shared write port
  // ----------------------------------------------------------------
  logic bus_ack;
  wire logic [2:0] bus_idx = avs_address[AVS_IDX_LSB+2:AVS_IDX_LSB];
  wire logic bus_mapped = (avs_address[AVS_ADDR_W-1] == 1'b0);
  wire logic bus_req = avs_read | avs_write;
  // an i2c commit owns the write port, so the bus waits one more cycle
  assign avs_waitrequest = bus_req & (~bus_ack | i2c_wr_stb);
  wire logic bus_wr = avs_write & ~avs_waitrequest & bus_mapped;
  logic [15:0] bus_cur;

  always_comb
  begin
    bus_cur = (bus_idx == REG_STATUS) ? 16'h0000 : reg_value(bus_idx);
  end
  wire logic [15:0] bus_wdata = {avs_byteenable[1] ? avs_writedata[15:8] : bus_cur[15:8],
                                 avs_byteenable[0] ? avs_writedata[7:0] : bus_cur[7:0]};
  wire logic wr_stb = i2c_wr_stb | bus_wr;
  wire logic [2:0] wr_idx = i2c_wr_stb ? i2c_wr_idx : bus_idx;
  wire logic [15:0] wr_data = i2c_wr_stb ? i2c_wr_data : bus_wdata;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      bus_ack <= avs_waitrequest;
      if (bus_req && !bus_ack)
      begin
        avs_readdata <= bus_mapped ? {16'h0000, reg_value(bus_idx)} : 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  logic [31:0] auto_cnt;
  wire logic [31:0] auto_period = 32'(AUTO_BASE) << (cyc - 3'h1);
  wire logic auto_tick = auto_mode && (auto_cnt >= auto_period - 32'h1);

  always_ff @(posedge clock)
  begin
    if (rst || !auto_mode)
    begin
      auto_cnt <= 32'h0;
    end
    else
    begin
      auto_cnt <= auto_tick ? 32'h0 : auto_cnt + 32'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= auto_tick | (rd_trig & ~auto_mode);
    end
  end

  assign osc_enable = auto_mode;

  // ----------------------------------------------------------------
  // limits, alert flags and trackers
  // ----------------------------------------------------------------
  wire logic hold = config_q[CFG_HOLD];
  wire logic over_set = conv_done && (conv_data > high_lim);
  wire logic under_set = conv_done && (conv_data < low_lim);
  wire logic over_fall = conv_done && !hold &&
                         ({1'b0, conv_data} + {1'b0, hyst} < {1'b0, high_lim});
  wire logic under_rise = conv_done && !hold &&
                          ({1'b0, conv_data} > {1'b0, low_lim} + {1'b0, hyst});
  wire logic st_wr = wr_stb && (wr_idx == REG_STATUS);
  // a violation in the clearing cycle wins, so no event is lost
  wire logic next_over = over_set | (over_q & ~over_fall & ~(st_wr & wr_data[ST_OVER]));
  wire logic next_under = under_set | (under_q & ~under_rise & ~(st_wr & wr_data[ST_UNDER]));
  wire logic pin_act = config_q[CFG_PIN_EN] & alert_any;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      over_q <= 1'b0;
      under_q <= 1'b0;
      alert_out <= 1'b1;
    end
    else
    begin
      over_q <= next_over;
      under_q <= next_under;
      alert_out <= config_q[CFG_POLARITY] ? pin_act : ~pin_act;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      config_q <= CONFIG_RST;
      low_lim <= LOW_LIM_RST;
      high_lim <= HIGH_LIM_RST;
      hyst <= HYST_RST;
      result <= RESULT_RST;
    end
    else
    begin
      if (conv_done)
      begin
        result <= conv_data;
      end
      if (wr_stb)
      begin
        case (wr_idx)
          REG_CONFIG: config_q <= wr_data[7:0];
          REG_LOW_LIM: low_lim <= wr_data[11:0];
          REG_HIGH_LIM: high_lim <= wr_data[11:0];
          REG_HYST: hyst <= wr_data[11:0];
          default: ;
        endcase
      end
    end
  end

  // software writes win over a same-cycle tracker update
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lowest <= LOWEST_RST;
      highest <= HIGHEST_RST;
    end
    else
    begin
      if (wr_stb && wr_idx == REG_LOWEST)
        lowest <= wr_data[11:0];
      else if (auto_mode && conv_done && conv_data < lowest)
        lowest <= conv_data;
      if (wr_stb && wr_idx == REG_HIGHEST)
        highest <= wr_data[11:0];
      else if (auto_mode && conv_done && conv_data > highest)
        highest <= conv_data;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_hs_code_nack: assert property (byte_end && byte_cnt == 2'h0 && is_hs_code
    |=> !sda_oe && hs_mode && state == ST_IDLE) else $error("hs code was acknowledged");
  a_rstart_keeps_hs: assert property (hs_mode && start_det
    |=> hs_mode && state == ST_RX) else $error("repeated start left hs mode");
  a_stop_ends_hs: assert property (stop_det |=> !hs_mode && !sda_oe)
    else $error("stop did not end hs mode");
  a_over_sets: assert property (over_set |=> over_q)
    else $error("over-range flag not set");
  a_under_sets: assert property (under_set |=> under_q)
    else $error("under-range flag not set");
  a_alert_level: assert property (##1 alert_out ==
    ($past(config_q[CFG_POLARITY]) ~^ $past(pin_act))) else $error("alert level wrong");
  a_hold_persist: assert property (hold && over_q && !(st_wr && wr_data[ST_OVER])
    |=> over_q) else $error("held alert cleared itself");
  a_max_track: assert property (auto_mode && conv_done && conv_data > highest
    && !(wr_stb && wr_idx == REG_HIGHEST) |=> highest == $past(conv_data))
    else $error("highest tracker missed a maximum");
  a_no_idle_start: assert property (!auto_mode && !rd_trig |=> !conv_start)
    else $error("conversion started without cause");

  c_hs_entry: cover property (hs_mode ##[1:1000] start_det);
  c_over_alert: cover property (over_set ##1 over_q);
  c_read_byte: cover property (state == ST_TX ##[1:1000] state == ST_RACK);
  c_auto_conv: cover property (auto_tick ##1 conv_start);

endmodule // aam_monitor

// [hw/aam_pkg.sv]
package aam_pkg;

  // ----------------------------------------------------------------
  // register indices (i2c pointer value, avalon word index)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_RESULT = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CONFIG = 3'h2;
  localparam logic [2:0] REG_LOW_LIM = 3'h3;
  localparam logic [2:0] REG_HIGH_LIM = 3'h4;
  localparam logic [2:0] REG_HYST = 3'h5;
  localparam logic [2:0] REG_LOWEST = 3'h6;
  localparam logic [2:0] REG_HIGHEST = 3'h7;
  localparam int AVS_ADDR_W = 6;
  localparam int AVS_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_CYC_MSB = 7;
  localparam int CFG_CYC_LSB = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CFG_PIN_EN = 2;
  localparam int CFG_POLARITY = 0;
  localparam int ST_OVER = 1;
  localparam int ST_UNDER = 0;
  localparam int ST_HS = 4;
  localparam int RES_ALERT = 15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [11:0] LOW_LIM_RST = 12'h000;
  localparam logic [11:0] HIGH_LIM_RST = 12'hFFF;
  localparam logic [11:0] HYST_RST = 12'h000;
  localparam logic [11:0] LOWEST_RST = 12'hFFF;
  localparam logic [11:0] HIGHEST_RST = 12'h000;
  localparam logic [11:0] RESULT_RST = 12'h000;

  // ----------------------------------------------------------------
  // target addresses and codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_FLOAT = 7'h50;
  localparam logic [6:0] ADDR_GND = 7'h51;
  localparam logic [6:0] ADDR_SUPPLY = 7'h52;
  localparam logic [6:0] ADDR_FIXED = 7'h54;
  localparam logic [1:0] SEL_FLOAT = 2'h0;
  localparam logic [1:0] SEL_GND = 2'h1;
  localparam logic [1:0] SEL_SUPPLY = 2'h2;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int AUTO_BASE_US = 5000;
  localparam int AUTO_BASE_CYC = AUTO_BASE_US * CLOCK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b011,
    ST_TX = 3'b010,
    ST_RACK = 3'b110
  } aam_state_e;

endpackage

// [verif/aam_i2c_ctrl.sv]
`timescale 1ns/10ps
// ----------------------------------------
// i2c bus controller model, 160 ns bit time
// ----------------------------------------
module aam_i2c_ctrl
(
  input wire logic clock,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic half();
    repeat (16) @(posedge clock);
  endtask
  // also serves as repeated start from a low clock
  task automatic start();
    sda <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  task automatic stop();
    repeat (4) @(posedge clock);
    sda <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask
  // data moves a few clocks after the fall so it never races the clock edge
  task automatic bit_x(input logic b, output logic q);
    repeat (4) @(posedge clock);
    sda <= b;
    repeat (12) @(posedge clock);
    scl <= 1'b1;
    half();
    q = sda_wire;
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
    output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], q[i]);
    end
    bit_x(mack, ack);
  endtask
endmodule // aam_i2c_ctrl

// [verif/adc_alert_i2c_monitor_bench.sv]
`timescale 1ns/10ps
module adc_alert_i2c_monitor_bench;
  import aam_pkg::*;
  logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, conv_done = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic avs_waitrequest, scl_in, sda_w, ctl_sda, sda_out, sda_oe, conv_start, ak;
  logic osc_enable, alert_out, hs_active;
  logic [11:0] conv_data = 12'h000, cdata = 12'h000, emin = 12'hFFF, emax = 12'h000;
  logic [11:0] lo = 12'h100, hi = 12'h800, hy = 12'h010;
  logic [11:0] seq [6] = '{12'h900, 12'h7F0, 12'h7EF, 12'h0FF, 12'h110, 12'h111};
  logic [1:0] est = 2'h0, strap = SEL_GND;
  logic [7:0] cfg = 8'h00, rb;
  logic [15:0] lf = 16'h0063, q;
  int mismatches = 0, n_tests = 0;
  assign sda_w = ctl_sda & (sda_oe ? sda_out : 1'b1);
  aam_monitor #(.HAS_ADDR_PIN(1'b1), .AUTO_BASE(50)) DUT (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(strap), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .osc_enable(osc_enable), .alert_out(alert_out),
    .hs_active(hs_active));
  aam_i2c_ctrl ctl (.clock(clock), .sda_wire(sda_w), .scl(scl_in), .sda(ctl_sda));
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  // converter stand-in answers every start one cycle later
  always @(posedge clock)
  begin
    conv_done <= (conv_start === 1'b1);
    conv_data <= cdata;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // flag model; compares are strict at both hysteresis edges
  function automatic logic [1:0] nx_st(input logic [11:0] d, input logic [1:0] s);
    logic ov, un;
    ov = (d > hi) | (s[1] & (cfg[CFG_HOLD] | (({1'b0, d} + {1'b0, hy}) >= {1'b0, hi})));
    un = (d < lo) | (s[0] & (cfg[CFG_HOLD] | ({1'b0, d} <= ({1'b0, lo} + {1'b0, hy}))));
    return {ov, un};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [5:0] a, input logic [15:0] d,
    output logic [15:0] r);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata[15:0];
    if (n >= 50)
    begin
      chk("avalon timeout", 16'h0001, 16'h0000);
      summarize();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rc(input string nm, input logic [2:0] idx, input logic [15:0] exp);
    av(1'b0, {1'b0, idx, 2'b00}, 16'h0000, q);
    chk(nm, q, exp);
  endtask
  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    av(1'b1, {1'b0, idx, 2'b00}, d, q);
  endtask
  task automatic cf(input logic [7:0] v);
    cfg = v;
    wr(REG_CONFIG, {8'h00, v});
  endtask
  // hold one input value for more than two auto periods, then compare everything visible
  task automatic step(input logic [11:0] d);
    cdata <= d;
    repeat (120) @(posedge clock);
    est = nx_st(d, est);
    if (d < emin) emin = d;
    if (d > emax) emax = d;
    rc("status", REG_STATUS, {14'h0000, est});
    rc("result", REG_RESULT, {cfg[CFG_FLAG_EN] & (|est), 3'h0, d});
    rc("lowest", REG_LOWEST, {4'h0, emin});
    rc("highest", REG_HIGHEST, {4'h0, emax});
    chk("alert", {15'h0000, alert_out},
      {15'h0000, (cfg[CFG_PIN_EN] & (|est)) ^ ~cfg[CFG_POLARITY]});
    chk("oscillator", osc_enable, |cfg[CFG_CYC_MSB:CFG_CYC_LSB]);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    rc("config rst", REG_CONFIG, 16'h0000);
    rc("high rst", REG_HIGH_LIM, 16'h0FFF);
    rc("lowest rst", REG_LOWEST, 16'h0FFF);
    av(1'b0, 6'h20, 16'h0000, q);
    chk("unmapped", q, 16'h0000);
    done("reset");
    ctl.start();
    ctl.xfer({ADDR_GND, 1'b0}, 1'b1, rb, ak);
    chk("own address ack", ak, 16'h0000);
    ctl.xfer({5'h00, REG_HIGH_LIM}, 1'b1, rb, ak);
    ctl.xfer(8'h0A, 1'b1, rb, ak);
    ctl.xfer(8'hBC, 1'b1, rb, ak);
    ctl.stop();
    rc("i2c write", REG_HIGH_LIM, 16'h0ABC);
    ctl.start();
    ctl.xfer({ADDR_FLOAT, 1'b0}, 1'b1, rb, ak);
    chk("other address nack", ak, 16'h0001);
    ctl.stop();
    ctl.start();
    ctl.xfer({ADDR_GND, 1'b1}, 1'b1, rb, ak);
    // quiet read: the clock idles 1 us before the upper byte
    repeat (200) @(posedge clock);
    ctl.xfer(8'hFF, 1'b0, rb, ak);
    chk("read upper", rb, 16'h000A);
    ctl.xfer(8'hFF, 1'b1, rb, ak);
    chk("read lower", rb, 16'h00BC);
    ctl.stop();
    done("i2c");
    ctl.start();
    ctl.xfer({HS_CODE_TOP, 3'h3}, 1'b1, rb, ak);
    chk("hs code nack", ak, 16'h0001);
    chk("hs entered", hs_active, 16'h0001);
    ctl.start();
    ctl.xfer({ADDR_GND, 1'b0}, 1'b1, rb, ak);
    chk("hs address ack", ak, 16'h0000);
    chk("hs kept", hs_active, 16'h0001);
    ctl.stop();
    repeat (8) @(posedge clock);
    chk("hs left", hs_active, 16'h0000);
    done("high speed");
    wr(REG_LOW_LIM, {4'h0, lo});
    wr(REG_HIGH_LIM, {4'h0, hi});
    wr(REG_HYST, {4'h0, hy});
    cdata <= 12'h900;
    cf(8'h2C);
    foreach (seq[i]) step(seq[i]);
    done("window");
    cf(8'h3C);
    step(12'h900);
    step(12'h400);
    wr(REG_STATUS, 16'h0002);
    est = 2'h0;
    rc("write one clear", REG_STATUS, 16'h0000);
    step(12'h400);
    step(12'h900);
    wr(REG_STATUS, 16'h0002);
    est = 2'h0;
    step(12'h900);
    cf(8'h3D);
    step(12'h900);
    cf(8'h39);
    cdata <= 12'h300;
    wr(REG_HIGHEST, 16'h0000);
    emax = 12'h000;
    step(12'h300);
    done("hold");
    cf(8'h2C);
    repeat (6)
    begin
      lf = lfsr(lf);
      step(lf[11:0]);
    end
    done("random");
    // second reset re-captures the strap; a result read outside auto mode converts
    cdata <= 12'h5A5;
    strap <= SEL_SUPPLY;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    ctl.start();
    ctl.xfer({ADDR_SUPPLY, 1'b1}, 1'b1, rb, ak);
    chk("supply address ack", ak, 16'h0000);
    ctl.xfer(8'hFF, 1'b1, rb, ak);
    ctl.stop();
    rc("read triggers conversion", REG_RESULT, 16'h05A5);
    done("strap");
    summarize();
  end
endmodule // adc_alert_i2c_monitor_bench
